// [rtl/adc_conversion_serial_readout.v]
// Conversion sequencer and serial result shifter of the delta-sigma converter
`include "adc_readout_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_serial_readout (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Serial link pins, sampled on clk_i
  input wire sck_i,
  input wire cs_n_i,
  output reg data_ready_out_o,
  output reg data_ready_oe_o,
  // Modulator result, sampled at the end of each conversion
  input wire [21:0] conv_value_i,
  input wire overrange_high_flag_i,
  input wire overrange_low_flag_i,
  // Status
  output reg converting_o,
  output reg shutdown_o,
  output reg calibrating_o,
  output reg overrange_high_flag_o,
  output reg overrange_low_flag_o
);
  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [3:0] ST_SLEEP = 4'h1;
  localparam [3:0] ST_WAKE = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  localparam [2:0] SH_IDLE = 3'h1;
  localparam [2:0] SH_READY = 3'h2;
  localparam [2:0] SH_SHIFT = 3'h4;

  // Edge flag from a two-sample history
  function edge_seen;
    input prev_v;
    input curr_v;
    input want_rise;
    begin
      edge_seen = want_rise ? (~prev_v & curr_v) : (prev_v & ~curr_v);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  reg sck_meta, sck_sync, sck_prev;
  reg cs_meta, cs_sync, cs_prev;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      sck_meta <= sck_i;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // Falling clock edges shift the bits and the rising edge after the last bit closes the frame
  // Edges are qualified by select, so the idle level never counts
  wire sck_fall = edge_seen(sck_prev, sck_sync, 1'b0) & ~cs_sync & ~cs_prev;
  wire sck_rise = edge_seen(sck_prev, sck_sync, 1'b1) & ~cs_sync & ~cs_prev;
  wire cs_fall = edge_seen(cs_prev, cs_sync, 1'b0);
  wire cs_rise = edge_seen(cs_prev, cs_sync, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick divided from clk_i
  reg [15:0] osc_cnt;
  wire osc_tick = (osc_cnt == `OSC_DIV - 16'h0001);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      osc_cnt <= 16'h0000;
    else if (osc_tick)
      osc_cnt <= 16'h0000;
    else
      osc_cnt <= osc_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  reg [3:0] state;
  reg [15:0] period_cnt;
  reg single_armed;
  reg start_pending;
  reg first_after_reset;
  wire buf_in_ready;
  wire conv_end = (state == ST_CONV) && osc_tick && (period_cnt == `CONV_PERIODS - 16'h0001);
  wire [23:0] result_word = {overrange_high_flag_i, overrange_low_flag_i, conv_value_i};

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_SLEEP;
      period_cnt <= 16'h0000;
      single_armed <= 1'b0;
      start_pending <= 1'b0;
      first_after_reset <= 1'b1;
    end else begin
      first_after_reset <= 1'b0;
      // A select fall while busy is remembered and restarts the next conversion
      if (cs_fall)
        start_pending <= 1'b1;
      else if (state == ST_SLEEP || (state == ST_HOLD && buf_in_ready))
        start_pending <= 1'b0;
      // Rising select before the next result ends continuous running
      if (cs_rise)
        single_armed <= 1'b1;
      else if (cs_fall)
        single_armed <= 1'b0;
      case (state)
        ST_SLEEP: begin
          // Select low at reset release starts without host action
          if (cs_fall || (first_after_reset && !cs_sync)) begin
            state <= ST_WAKE;
            period_cnt <= 16'h0000;
          end
        end
        ST_WAKE: begin
          // Wake-up adds extra oscillator periods to the first conversion
          if (osc_tick) begin
            if (period_cnt == `WAKE_PERIODS - 16'h0001) begin
              state <= ST_CONV;
              period_cnt <= 16'h0000;
            end else
              period_cnt <= period_cnt + 16'h0001;
          end
        end
        ST_CONV: begin
          // CONV_PERIODS oscillator periods per result, calibration inside the same window
          if (osc_tick) begin
            if (conv_end)
              state <= ST_HOLD;
            else
              period_cnt <= period_cnt + 16'h0001;
          end
        end
        ST_HOLD: begin
          // Period counter is cleared between conversions
          period_cnt <= 16'h0000;
          if (buf_in_ready) begin
            if (start_pending || cs_fall)
              state <= ST_CONV;
            else if (!cs_sync && !single_armed)
              state <= ST_CONV;
            else
              state <= ST_SLEEP;
          end
        end
        default: state <= ST_SLEEP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer: a slow host stalls the sequencer in the hold state
  wire buf_valid;
  wire [23:0] buf_data;
  reg buf_take;

  result_buffer u_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .flush_i(1'b0),
    .in_valid_i(state == ST_HOLD),
    .in_ready_o(buf_in_ready),
    .in_data_i(result_word),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_take),
    .out_data_o(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter
  reg [2:0] sh_state;
  reg [23:0] shift_reg;
  reg [4:0] bit_cnt;
  reg [2:0] next_sh_state;

  always @* begin
    next_sh_state = sh_state;
    buf_take = 1'b0;
    case (sh_state)
      SH_IDLE: begin
        if (buf_valid && !cs_sync) begin
          next_sh_state = SH_READY;
          buf_take = 1'b1;
        end
      end
      SH_READY: begin
        if (sck_fall)
          next_sh_state = SH_SHIFT;
      end
      SH_SHIFT: begin
        // The frame closes on the host's sampling edge after the last bit, so 24 falls suffice
        if (sck_rise && bit_cnt == `BIT_CNT_LAST)
          next_sh_state = SH_IDLE;
      end
      default: next_sh_state = SH_IDLE;
    endcase
    if (cs_sync)
      next_sh_state = SH_IDLE;
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_state <= SH_IDLE;
      shift_reg <= 24'h000000;
      bit_cnt <= 5'h00;
    end else begin
      sh_state <= next_sh_state;
      if (buf_take) begin
        shift_reg <= buf_data;
        bit_cnt <= 5'h00;
      end else if (sck_fall && sh_state == SH_SHIFT && bit_cnt != `BIT_CNT_LAST) begin
        shift_reg <= {shift_reg[22:0], 1'b0};
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; the host samples on the rising edge after each change
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_ready_out_o <= 1'b1;
      data_ready_oe_o <= 1'b0;
    end else begin
      data_ready_oe_o <= ~cs_sync;
      if (cs_sync)
        data_ready_out_o <= 1'b1;
      else if (sh_state == SH_IDLE)
        data_ready_out_o <= ~(buf_valid);
      else if (sh_state == SH_READY && sck_fall)
        data_ready_out_o <= shift_reg[`FLAG_HIGH_POS];
      else if (sh_state == SH_SHIFT && sck_rise && bit_cnt == `BIT_CNT_LAST)
        data_ready_out_o <= 1'b1; // Idle high once bit 0 has been sampled
      else if (sh_state == SH_SHIFT && sck_fall && bit_cnt != `BIT_CNT_LAST)
        data_ready_out_o <= shift_reg[`FLAG_HIGH_POS - 1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      converting_o <= 1'b0;
      shutdown_o <= 1'b1;
      calibrating_o <= 1'b0;
      overrange_high_flag_o <= 1'b0;
      overrange_low_flag_o <= 1'b0;
    end else begin
      converting_o <= (state == ST_CONV) || (state == ST_WAKE);
      shutdown_o <= (state == ST_SLEEP);
      calibrating_o <= (state == ST_CONV);
      if (conv_end) begin
        overrange_high_flag_o <= overrange_high_flag_i;
        overrange_low_flag_o <= overrange_low_flag_i;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/adc_readout_regs.vh]
// Constants for the conversion sequencer and serial readout of the delta-sigma converter
`ifndef ADC_READOUT_REGS_VH
`define ADC_READOUT_REGS_VH

// Result word layout
`define WORD_BITS 24
`define DATA_BITS 22
`define FLAG_HIGH_POS 23
`define FLAG_LOW_POS 22
`define BIT_CNT_W 5
`define BIT_CNT_LAST 5'h17

// Conversion timing in oscillator periods, oscillator divided from clk_i
// One oscillator period per clk_i; the divide ratio is arbitrary and keeps runs short
`define OSC_DIV 16'h0001
`define CONV_PERIODS 16'h2000
`define WAKE_PERIODS 16'h0090

`endif

// [rtl/result_buffer.v]
// Two-entry result buffer between the conversion engine and the serial shifter
`timescale 1ns/1ps
`default_nettype none
module result_buffer (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  input wire flush_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [23:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [23:0] out_data_o
);
  reg [23:0] mem0;
  reg [23:0] mem1;
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;

  // Storage writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem0 <= 24'h000000;
      mem1 <= 24'h000000;
    end else if (do_wr) begin
      if (wr_ptr)
        mem1 <= in_data_i;
      else
        mem0 <= in_data_i;
    end
  end

  // Registered read data follows the head entry
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      out_data_o <= 24'h000000;
    else if (do_wr && (count == 2'h0 || (count == 2'h1 && do_rd)))
      out_data_o <= in_data_i;
    else if (do_rd)
      out_data_o <= rd_ptr ? mem0 : mem1;
  end

  // Pointers and fill level; flush drops stale results, but the sequencer ties it low
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (flush_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_wr)
        wr_ptr <= ~wr_ptr;
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule
`default_nettype wire

// [tb/readout_checker.sv]
// Concurrent checks on the ports of the conversion sequencer and serial readout
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_regs.vh"
module readout_checker (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Serial link pins
  input wire sck_i,
  input wire cs_n_i,
  input wire data_ready_out_o,
  input wire data_ready_oe_o,
  // Flags and status
  input wire overrange_high_flag_i,
  input wire overrange_low_flag_i,
  input wire converting_o,
  input wire shutdown_o,
  input wire calibrating_o,
  input wire overrange_high_flag_o,
  input wire overrange_low_flag_o
);
  localparam int WAKE_CLKS = `WAKE_PERIODS * `OSC_DIV;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic sck_d;
  logic [3:0] since_fall;
  logic [15:0] wake_cnt;
  //////////////////////////////////////////////////////////////////////////////
  // Cycles since the raw serial clock fell; saturates so a long idle never wraps
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_d <= 1'b1;
      since_fall <= 4'hF;
    end else begin
      sck_d <= sck_i;
      if (sck_d && !sck_i) since_fall <= 4'h0;
      else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
    end
  end
  // Length of the wake phase, from converting high until the window opens
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) wake_cnt <= 16'h0000;
    else if (!converting_o || calibrating_o) wake_cnt <= 16'h0000;
    else wake_cnt <= wake_cnt + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_oe_released: assert property (cs_n_i [*4] |-> !data_ready_oe_o)
    else $error("output enable stays on with select high");
  a_oe_driven: assert property (!cs_n_i [*6] |-> data_ready_oe_o)
    else $error("output enable off with select low");
  a_bit_on_fall: assert property (data_ready_oe_o && $past(data_ready_oe_o) && $rose(data_ready_out_o)
    |-> since_fall < 4'h7) else $error("data rose without a serial clock fall");
  a_start_on_select: assert property ($fell(cs_n_i) && shutdown_o |-> ##[1:6] converting_o)
    else $error("no conversion after select fell");
  a_wake_length: assert property ($rose(calibrating_o) |-> wake_cnt < 16'h0004 ||
    (int'(wake_cnt) > WAKE_CLKS - 8 && int'(wake_cnt) < WAKE_CLKS + 8)) else $error("wake phase length wrong");
  a_cal_in_conv: assert property (calibrating_o |-> converting_o)
    else $error("calibration outside a conversion");
  a_high_flag: assert property ($changed(overrange_high_flag_o) |->
    overrange_high_flag_o == $past(overrange_high_flag_i)) else $error("high flag not from input");
  a_low_flag: assert property ($changed(overrange_low_flag_o) |->
    overrange_low_flag_o == $past(overrange_low_flag_i)) else $error("low flag not from input");
  a_idle_sleeps: assert property (!converting_o [*8] |-> shutdown_o)
    else $error("idle without shutdown");
  a_sleep_excl: assert property (!(shutdown_o && converting_o))
    else $error("asleep while converting");
endmodule
`default_nettype wire

// [tb/spi_host_model.sv]
// Host serial master model: drives select and serial clock, samples the data line
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock used for bounded waits
  input wire clk_i,
  // Serial link
  input wire data_ready_out_i,
  input wire data_ready_oe_i,
  output logic sck_o,
  output logic cs_n_o
);
  logic last = 1'b0;
  logic line;
  // A released line shows the inverse of its last value, so a stale bit never matches
  always @(posedge clk_i) if (data_ready_oe_i) last <= data_ready_out_i;
  always @* line = data_ready_oe_i ? data_ready_out_i : ~last;
  // Select tied low at power-up, clock resting high
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task select(input logic s);
    @(posedge clk_i);
    cs_n_o <= !s;
  endtask
  // Serial clock toggles, used while deselected
  task wiggle(input int k);
    repeat (k) begin
      repeat (4) @(posedge clk_i);
      sck_o <= ~sck_o;
    end
  endtask
  // Waits for the ready low level, never longer than lim cycles
  task wait_ready(input int lim, output int n);
    n = 0;
    while (line !== 1'b0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // One word of 24 falls; a low resting clock first rises so either mode works
  task read_word(output logic [23:0] w);
    logic idle;
    idle = sck_o;
    @(posedge clk_i);
    if (!idle) begin
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    for (int i = 23; i >= 0; i--) begin
      sck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      w[i] = line;
      repeat (4) @(posedge clk_i);
    end
    sck_o <= idle;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the conversion sequencer and serial readout
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_regs.vh"
module tb;
  localparam int CONV_CLKS = `CONV_PERIODS * `OSC_DIV;
  localparam int WAKE_CLKS = `WAKE_PERIODS * `OSC_DIV;
  logic clk_i;
  logic resetn_i;
  logic [21:0] conv_value = 22'h1A5F3C;
  logic flag_high = 1'b1;
  logic flag_low = 1'b0;
  wire sck, cs_n, dout, doe, converting, shutdown, calibrating, flag_high_o, flag_low_o;
  int errors = 0;
  int comparisons = 0;
  int n;
  logic [23:0] w;
  //////////////////////////////////////////////////////////////////////////////
  adc_conversion_serial_readout uut (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
    .data_ready_out_o(dout), .data_ready_oe_o(doe), .conv_value_i(conv_value),
    .overrange_high_flag_i(flag_high), .overrange_low_flag_i(flag_low), .converting_o(converting),
    .shutdown_o(shutdown), .calibrating_o(calibrating), .overrange_high_flag_o(flag_high_o),
    .overrange_low_flag_o(flag_low_o));
  spi_host_model host (.clk_i(clk_i), .data_ready_out_i(dout), .data_ready_oe_i(doe), .sck_o(sck), .cs_n_o(cs_n));
  //////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check_range(input string what, input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; three conversions and reads need about 25 thousand cycles
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #2000000;
    errors++;
    tally_and_finish;
  end
  // Power-up converting, continuous run, single conversion, then a fresh start
  initial begin
    resetn_i = 1'b0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    host.wait_ready(WAKE_CLKS + CONV_CLKS + 201, n);
    check_range("first ready", n, WAKE_CLKS + CONV_CLKS - 200, WAKE_CLKS + CONV_CLKS + 200);
    host.read_word(w);
    check("word one", {2'b10, 22'h1A5F3C}, w);
    check("high flag", 24'h1, {23'h0, flag_high_o});
    @(posedge clk_i);
    conv_value <= 22'h2A0001;
    flag_high <= 1'b0;
    flag_low <= 1'b1;
    host.wait_ready(CONV_CLKS + 201, n);
    check_range("second ready", n, CONV_CLKS - 600, CONV_CLKS + 200);
    host.read_word(w);
    check("word two", {2'b01, 22'h2A0001}, w);
    check("low flag", 24'h1, {23'h0, flag_low_o});
    @(posedge clk_i);
    conv_value <= 22'h155555;
    flag_low <= 1'b0;
    host.select(1'b0);
    repeat (4) @(posedge clk_i);
    check("released", 24'h0, {23'h0, doe});
    host.wiggle(49);
    repeat (CONV_CLKS) @(posedge clk_i);
    check("asleep", 24'h1, {23'h0, shutdown});
    host.select(1'b1);
    host.wait_ready(20, n);
    check_range("held ready", n, 0, 19);
    repeat (8) @(posedge clk_i);
    check("restart", 24'h1, {23'h0, converting});
    host.read_word(w);
    check("word three", {2'b00, 22'h155555}, w);
    host.select(1'b0);
    tally_and_finish;
  end
endmodule
bind adc_conversion_serial_readout readout_checker chk (.clk_i, .resetn_i, .sck_i, .cs_n_i, .data_ready_out_o,
  .data_ready_oe_o, .overrange_high_flag_i, .overrange_low_flag_i, .converting_o, .shutdown_o, .calibrating_o,
  .overrange_high_flag_o, .overrange_low_flag_o);
`default_nettype wire
